// File: verilog/raws_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - Alarm month/date/hour/minute/second registers 0Ah-0Eh are compared with clock
// - Repeat bits select compared fields: second, minute, hour, day, month
// - Undefined repeat codes fire the alarm every second
// - Match sets alarm flag; with flag enable also drives interrupt pin
// - Alarm flag and interrupt withheld while pointer rests on flags address
// - Flags read releases interrupt; second read shows alarm flag cleared
// - In back-up, alarm drives pin only with backup and flag enables set
// - Power-up clears alarm backup enable and alarm flag enable
// - Watchdog register holds 5-bit multiplier and 2-bit resolution; timeout is product
// - Watchdog expiry sets watchdog flag, cleared by flags read
// - Steering zero asserts interrupt; steering one pulses reset for recovery time
// - Reset-steered expiry clears watchdog register and AFE, ABE, SQUARE_WAVE_ENABLE_BIT, FT
// - Either kick-pin edge or watchdog register write restarts the period
// - Writing 00h to watchdog register releases interrupt and disables watchdog
// - Power-up clears watchdog register, watchdog disabled
// - Watchdog interrupt steering wins over frequency test output
// - Four-bit rate field at 13h selects square-wave frequency
// - Square-wave pin active only while enable bit in 0Ah is set
// - 32 kHz pin runs unless oscillator stopped or in back-up
// - Reset output low on supply fail, held recovery time after restore
// - Two filtered reset requests act like a power cycle with recovery release
// - Recovery select and stop bit choose recovery interval, default 96 ms
// - Flags are read-only; alarm and watchdog flags set by events, cleared by reads; battery-low is live
module raws_supervisor #(
	parameter int REC_CYC     = raws_pkg::REC_CYCLES,
	parameter int STOP_CYC    = raws_pkg::STOP_REC_CYCLES,
	parameter int SLOW_CYC    = raws_pkg::RQ_SLOW_CYCLES,
	parameter int HALF_CYC    = raws_pkg::CYC_PER_OSC
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	// Register port from the serial engine
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	output logic      [7:0]  regRdata,
	input  wire logic [7:0]  addrPointer,
	// Running clock (BCD) and second-update strobe
	input  wire logic        secondsUpdate,
	input  wire logic [7:0]  clockMonth,
	input  wire logic [7:0]  clockDate,
	input  wire logic [7:0]  clockHour,
	input  wire logic [7:0]  clockMin,
	input  wire logic [7:0]  clockSec,
	// Control bits held elsewhere
	input  wire logic        oscillatorStopBit,
	input  wire logic        recoveryTimeSelect,
	input  wire logic        outputLevelBit,
	input  wire logic        batteryLow,
	input  wire logic        batteryBackup,
	input  wire logic        powerFailTrip,
	// Pins
	input  wire logic        watchdogKickInput,
	input  wire logic        resetRequestFastN,
	input  wire logic        resetRequestSlowN,
	output logic             sharedIrqOut,
	output logic             sharedIrqOeN,
	output logic             resetOut,
	output logic             resetOeN,
	output logic             squareWavePin,
	output logic             fixed32kClockPin,
	output logic             frequencyTestBit
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  wdCtrl_ff;
	logic [7:0]  alMonth_ff;
	logic [7:0]  alDate_ff;
	logic [7:0]  alHour_ff;
	logic [7:0]  alMin_ff;
	logic [7:0]  alSec_ff;
	logic [3:0]  sqwRate_ff;
	logic        ftBit_ff;
	logic        wdFlag_ff;
	logic        alFlag_ff;
	logic        alIrq_ff;
	logic        wdIrq_ff;
	logic        alPending_ff;
	logic        kickPrev_ff;
	logic [31:0] wdCnt_ff;
	logic [31:0] recCnt_ff;
	logic        rstActive_ff;
	logic        sqw_ff;
	logic        fixed_32k_clock_pin_ff;
	logic [7:0]  rdata_ff;

	logic        oscTick;
	logic [15:0] chain;
	logic        fastReq;
	logic        slowReq;
	logic        flagsRead;
	logic        wdWrite;
	logic        wdExpire;
	logic        wdStep;
	logic        onFlags;
	logic [4:0]  rpt;
	logic        match;
	logic [31:0] recLen;
	logic        resetCause;

	raws_prescaler #(.HALF_CYCLES(HALF_CYC)) uPre (
		.clock   (clock),
		.rstn    (rstn),
		.run     (!oscillatorStopBit),
		.oscTick (oscTick),
		.chain   (chain)
	);
	raws_pulse_filter #(.MIN_CYCLES(raws_pkg::RQ_FAST_CYCLES)) uFast (
		.clock     (clock),
		.rstn      (rstn),
		.reqN      (resetRequestFastN),
		.qualified (fastReq)
	);
	raws_pulse_filter #(.MIN_CYCLES(SLOW_CYC)) uSlow (
		.clock     (clock),
		.rstn      (rstn),
		.reqN      (resetRequestSlowN),
		.qualified (slowReq)
	);

	// Chain bits 0..k all ones: one tick of 32768/2^k Hz, since the chain steps at twice 32768 Hz
	function automatic logic tapTick(input logic [15:0] ch, input int k);
		tapTick = 1'b1;
		for (int i = 0; i < 16; i++)
			if (i <= k && !ch[i])
				tapTick = 1'b0;
	endfunction : tapTick

	assign flagsRead = regRead && (regAddr == raws_pkg::OFF_FLAGS);
	assign wdWrite   = regWrite && (regAddr == raws_pkg::OFF_WATCHDOG);
	assign onFlags   = (addrPointer == raws_pkg::OFF_FLAGS);
	assign rpt = {alDate_ff[6], alDate_ff[7], alHour_ff[7], alMin_ff[7], alSec_ff[7]};

	// ----------------------------------------
	// Alarm compare
	// ----------------------------------------
	// Field equality ignoring the repeat bit
	function automatic logic fieldEq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
		fieldEq = ((a ^ b) & m) == 8'h00;
	endfunction : fieldEq

	always_comb
	begin
		logic s;
		logic mi;
		logic h;
		logic d;
		logic mo;
		s  = fieldEq(alSec_ff, clockSec, 8'h7F);
		mi = fieldEq(alMin_ff, clockMin, 8'h7F);
		h  = fieldEq(alHour_ff, clockHour, 8'h3F);
		d  = fieldEq(alDate_ff, clockDate, 8'h3F);
		mo = fieldEq(alMonth_ff, clockMonth, 8'h1F);
		case (rpt)
			5'b11111: match = 1'b1;
			5'b11110: match = s;
			5'b11100: match = s && mi;
			5'b11000: match = s && mi && h;
			5'b10000: match = s && mi && h && d;
			5'b00000: match = s && mi && h && d && mo;
			default:  match = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Alarm flag and interrupt; set beats read-clear
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn || resetCause)
		begin
			alFlag_ff    <= 1'b0;
			alIrq_ff     <= 1'b0;
			alPending_ff <= 1'b0;
		end
		else
		begin
			// Held event waits out the pointer sitting on flags
			if (secondsUpdate && match)
				alPending_ff <= 1'b1;
			else if (!onFlags)
				alPending_ff <= 1'b0;
			if (alPending_ff && !onFlags)
			begin
				alFlag_ff <= 1'b1;
				alIrq_ff  <= alMonth_ff[raws_pkg::BIT_AFE] &&
					(!batteryBackup || alMonth_ff[raws_pkg::BIT_ABE]);
			end
			else if (flagsRead)
			begin
				alFlag_ff <= 1'b0;
				alIrq_ff  <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register writes; power-up and reset-steered expiry clear control bits
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			wdCtrl_ff  <= raws_pkg::RESET_ZERO;
			alMonth_ff <= raws_pkg::RESET_ZERO;
			alDate_ff  <= raws_pkg::RESET_ZERO;
			alHour_ff  <= raws_pkg::RESET_ZERO;
			alMin_ff   <= raws_pkg::RESET_ZERO;
			alSec_ff   <= raws_pkg::RESET_ZERO;
			sqwRate_ff <= 4'h0;
			ftBit_ff   <= 1'b0;
		end
		else if (wdExpire && wdCtrl_ff[raws_pkg::BIT_WD_STEER])
		begin
			wdCtrl_ff  <= raws_pkg::RESET_ZERO;
			alMonth_ff <= alMonth_ff & 8'h1F;
			ftBit_ff   <= 1'b0;
		end
		else if (regWrite)
		begin
			case (regAddr)
				raws_pkg::OFF_WATCHDOG: wdCtrl_ff  <= regWdata;
				raws_pkg::OFF_AL_MONTH: alMonth_ff <= regWdata;
				raws_pkg::OFF_AL_DATE:  alDate_ff  <= regWdata;
				raws_pkg::OFF_AL_HOUR:  alHour_ff  <= regWdata;
				raws_pkg::OFF_AL_MIN:   alMin_ff   <= regWdata;
				raws_pkg::OFF_AL_SEC:   alSec_ff   <= regWdata;
				raws_pkg::OFF_SQW_RATE: sqwRate_ff <= regWdata[7:raws_pkg::BIT_RATE_LO];
				default:                ftBit_ff   <= ftBit_ff;
			endcase
		end
	end

	// ----------------------------------------
	// Watchdog counter, counts resolution steps
	// ----------------------------------------
	always_comb
	begin
		case (wdCtrl_ff[1:0])
			2'b00:   wdStep = tapTick(chain, raws_pkg::TAP_SIXTEENTH);
			2'b01:   wdStep = tapTick(chain, raws_pkg::TAP_QUARTER);
			2'b10:   wdStep = tapTick(chain, raws_pkg::TAP_SECOND);
			default: wdStep = tapTick(chain, raws_pkg::TAP_SECOND);
		endcase
	end
	// Four-second steps count four one-second ticks; low bits of count reused
	assign wdExpire = oscTick && wdStep && (wdCtrl_ff[6:2] != 5'h00) &&
		(wdCnt_ff[31:2] + 30'h1 >= {25'h0, wdCtrl_ff[6:2]}) &&
		((wdCtrl_ff[1:0] != 2'b11) || (wdCnt_ff[1:0] == 2'b11));

	always_ff @(posedge clock)
	begin
		if (!rstn)
			kickPrev_ff <= 1'b0;
		else
			kickPrev_ff <= watchdogKickInput;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn || wdWrite || (kickPrev_ff != watchdogKickInput) || wdExpire)
			wdCnt_ff <= 32'h0;
		else if (oscTick && wdStep)
			wdCnt_ff <= (wdCtrl_ff[1:0] == 2'b11) ? wdCnt_ff + 32'h1 : wdCnt_ff + 32'h4;
	end

	// Watchdog flag and interrupt; expiry wins over read-clear
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			wdFlag_ff <= 1'b0;
			wdIrq_ff  <= 1'b0;
		end
		else
		begin
			if (wdExpire)
				wdFlag_ff <= 1'b1;
			else if (flagsRead)
				wdFlag_ff <= 1'b0;
			if (wdExpire && !wdCtrl_ff[raws_pkg::BIT_WD_STEER])
				wdIrq_ff <= 1'b1;
			else if (wdWrite && regWdata == 8'h00)
				wdIrq_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Reset output and recovery time
	// ----------------------------------------
	assign resetCause = powerFailTrip || fastReq || slowReq ||
		(wdExpire && wdCtrl_ff[raws_pkg::BIT_WD_STEER]);
	assign recLen = recoveryTimeSelect ? 32'(raws_pkg::ALT_REC_CYCLES) :
		(oscillatorStopBit ? 32'(STOP_CYC) : 32'(REC_CYC));

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rstActive_ff <= 1'b1;
			recCnt_ff    <= 32'h0;
		end
		else if (resetCause)
		begin
			rstActive_ff <= 1'b1;
			recCnt_ff    <= 32'h0;
		end
		else if (rstActive_ff)
		begin
			// Recovery measured from cause release
			if (recCnt_ff + 32'h1 >= recLen)
				rstActive_ff <= 1'b0;
			recCnt_ff <= recCnt_ff + 32'h1;
		end
	end
	assign resetOut = 1'b0;
	assign resetOeN = !rstActive_ff;

	// ----------------------------------------
	// Square wave and 32 kHz outputs
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			sqw_ff  <= 1'b0;
			fixed_32k_clock_pin_ff <= 1'b0;
		end
		else
		begin
			fixed_32k_clock_pin_ff <= !oscillatorStopBit && !batteryBackup && chain[0];
			if (sqwRate_ff == 4'h0 || !alMonth_ff[raws_pkg::BIT_SQUARE_WAVE_ENABLE_BIT])
				sqw_ff <= 1'b0;
			else if (sqwRate_ff == 4'h1)
				sqw_ff <= chain[0];
			else
				sqw_ff <= chain[sqwRate_ff];
		end
	end
	assign squareWavePin    = sqw_ff;
	assign fixed32kClockPin = fixed_32k_clock_pin_ff;
	assign frequencyTestBit = ftBit_ff;

	// ----------------------------------------
	// Shared interrupt pin: alarm/watchdog, then test tone, then level
	// ----------------------------------------
	always_comb
	begin
		sharedIrqOut = 1'b0;
		if (alIrq_ff || wdIrq_ff)
			sharedIrqOeN = 1'b0;
		else if (ftBit_ff && !oscillatorStopBit)
			sharedIrqOeN = chain[6];
		else
			sharedIrqOeN = outputLevelBit;
	end

	// Read data: flags carry their live state
	always_ff @(posedge clock)
	begin
		if (!rstn)
			rdata_ff <= 8'h00;
		else if (regRead)
		begin
			case (regAddr)
				raws_pkg::OFF_WATCHDOG: rdata_ff <= wdCtrl_ff;
				raws_pkg::OFF_AL_MONTH: rdata_ff <= alMonth_ff;
				raws_pkg::OFF_AL_DATE:  rdata_ff <= alDate_ff;
				raws_pkg::OFF_AL_HOUR:  rdata_ff <= alHour_ff;
				raws_pkg::OFF_AL_MIN:   rdata_ff <= alMin_ff;
				raws_pkg::OFF_AL_SEC:   rdata_ff <= alSec_ff;
				raws_pkg::OFF_FLAGS:    rdata_ff <= {wdFlag_ff, alFlag_ff, 1'b0, batteryLow, 4'h0};
				raws_pkg::OFF_SQW_RATE: rdata_ff <= {sqwRate_ff, 4'h0};
				default:                rdata_ff <= 8'h00;
			endcase
		end
	end
	assign regRdata = rdata_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_WD_IRQ: assert property (@(posedge clock) disable iff (!rstn)
		wdExpire && !wdCtrl_ff[7] |=> !sharedIrqOeN)
		else $error("watchdog timeout did not drive interrupt");
	AST_WD_RST: assert property (@(posedge clock) disable iff (!rstn)
		wdExpire && wdCtrl_ff[7] |=> wdCtrl_ff == 8'h00 && !resetOeN && !alMonth_ff[7])
		else $error("reset-steered timeout did not clear controls");
	AST_WD_CLR: assert property (@(posedge clock) disable iff (!rstn)
		wdWrite && regWdata == 8'h00 && !wdExpire && !alIrq_ff |=> !wdIrq_ff)
		else $error("watchdog interrupt not released");
	AST_AL_HOLD: assert property (@(posedge clock) disable iff (!rstn)
		onFlags && !alFlag_ff |=> !$rose(alFlag_ff))
		else $error("alarm flag set while pointer on flags");
	AST_AL_SET: assert property (@(posedge clock) disable iff (!rstn || resetCause)
		secondsUpdate && match && !onFlags ##1 !onFlags && !resetCause |=> alFlag_ff)
		else $error("alarm flag not set on match");
	AST_FLAG_RD: assert property (@(posedge clock) disable iff (!rstn)
		flagsRead && !wdExpire |=> !wdFlag_ff)
		else $error("watchdog flag not cleared by read");
	AST_KICK: assert property (@(posedge clock) disable iff (!rstn)
		kickPrev_ff != watchdogKickInput |=> wdCnt_ff == 32'h0)
		else $error("kick edge did not restart watchdog");
	AST_RST_CAUSE: assert property (@(posedge clock) disable iff (!rstn)
		powerFailTrip |=> !resetOeN ##1 !resetOeN)
		else $error("reset not held after power fail");
	AST_SQW_OFF: assert property (@(posedge clock) disable iff (!rstn)
		!alMonth_ff[6] |=> !squareWavePin)
		else $error("square wave active while disabled");
endmodule : raws_supervisor

// File: verilog/raws_pkg.sv
package raws_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_WATCHDOG    = 8'h09;
	localparam logic [7:0] OFF_AL_MONTH    = 8'h0A;
	localparam logic [7:0] OFF_AL_DATE     = 8'h0B;
	localparam logic [7:0] OFF_AL_HOUR     = 8'h0C;
	localparam logic [7:0] OFF_AL_MIN      = 8'h0D;
	localparam logic [7:0] OFF_AL_SEC      = 8'h0E;
	localparam logic [7:0] OFF_FLAGS       = 8'h0F;
	localparam logic [7:0] OFF_SQW_RATE    = 8'h13;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_WD_STEER    = 7;
	localparam int BIT_AFE         = 7;
	localparam int BIT_SQUARE_WAVE_ENABLE_BIT        = 6;
	localparam int BIT_ABE         = 5;
	localparam int BIT_RPT_HI      = 7;
	localparam int BIT_FLAG_WD     = 7;
	localparam int BIT_FLAG_AL     = 6;
	localparam int BIT_RATE_LO     = 4;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	// ----------------------------------------
	// Timing: clock 250 MHz, 4 ns period
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 4;
	localparam int OSC_HZ          = 32768;
	localparam int CYC_PER_OSC     = 250000000 / (2 * OSC_HZ); // half period, rounded down
	localparam int REC_MIN_MS      = 96;
	localparam int REC_CYCLES      = (REC_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RQ_FAST_NS      = 200;
	localparam int RQ_FAST_CYCLES  = (RQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RQ_SLOW_MS      = 100;
	localparam int RQ_SLOW_CYCLES  = (RQ_SLOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALT_REC_US      = 50;
	localparam int ALT_REC_CYCLES  = (ALT_REC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STOP_REC_MS     = 40;
	localparam int STOP_REC_CYCLES = (STOP_REC_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Prescaler taps: tap k is a 32768 / 2^k Hz tick
	localparam int PRE_BITS        = 15;
	localparam int TAP_SIXTEENTH   = 11;
	localparam int TAP_QUARTER     = 13;
	localparam int TAP_SECOND      = 15;
endpackage : raws_pkg

// File: verilog/raws_pulse_filter.sv
`timescale 1ns/1ps
// Low-level qualifier: asserts request after input held low for minimum time,
// holds it until the input returns high.
module raws_pulse_filter #(
	parameter int MIN_CYCLES = 50
) (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic reqN,
	output logic      qualified
);
	logic [31:0] lowCnt_ff;
	// ----------------------------------------
	// Count low time, shorter pulses are dropped
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn || reqN)
			lowCnt_ff <= 32'h0;
		else if (lowCnt_ff < 32'(MIN_CYCLES))
			lowCnt_ff <= lowCnt_ff + 32'h1;
	end
	assign qualified = (lowCnt_ff >= 32'(MIN_CYCLES)) && !reqN;
endmodule : raws_pulse_filter

// File: verilog/raws_prescaler.sv
`timescale 1ns/1ps
// Oscillator divider: makes a tick at twice 32768 Hz and a binary chain of taps.
module raws_prescaler #(
	parameter int HALF_CYCLES = 3814
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        run,
	output logic             oscTick,
	output logic [15:0]      chain
);
	logic [15:0] divCnt_ff;
	logic [15:0] chain_ff;
	// ----------------------------------------
	// Fast clock to oscillator rate; chain bit 0 is the 32 kHz square wave
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn || !run)
		begin
			divCnt_ff <= 16'h0;
			chain_ff  <= 16'h0;
		end
		else if (divCnt_ff == 16'(HALF_CYCLES - 1))
		begin
			divCnt_ff <= 16'h0;
			chain_ff  <= chain_ff + 16'h1;
		end
		else
			divCnt_ff <= divCnt_ff + 16'h1;
	end
	assign oscTick = run && (divCnt_ff == 16'(HALF_CYCLES - 1));
	assign chain   = chain_ff;
endmodule : raws_prescaler

// File: bench/raws_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host processor model
// ----------------------------------------
module raws_host (
	input  wire logic       clock,
	output logic            regWrite,
	output logic            regRead,
	output logic [7:0]      regAddr,
	output logic [7:0]      regWdata,
	input  wire logic [7:0] regRdata,
	output logic [7:0]      addrPointer,
	output logic            watchdogKickInput,
	output logic            resetRequestFastN,
	output logic            resetRequestSlowN
);
	// Idle bus, request pins released high
	initial
	begin
		regWrite          = 1'b0;
		regRead           = 1'b0;
		regAddr           = 8'h00;
		regWdata          = 8'h00;
		addrPointer       = 8'h00;
		watchdogKickInput = 1'b0;
		resetRequestFastN = 1'b1;
		resetRequestSlowN = 1'b1;
	end
	// Pointer steps past the byte, so writing the last alarm byte parks it on flags
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr  = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clock);
		regWrite    = 1'b0;
		regWdata    = ~d; // Stale data must not look valid
		addrPointer = a + 8'h01;
	endtask : wr
	// Read strobe, data taken a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clock);
		regRead     = 1'b0;
		addrPointer = a + 8'h01;
		@(negedge clock);
		d = regRdata;
	endtask : rd
	// Either edge restarts the watchdog
	task automatic kick();
		@(negedge clock);
		watchdogKickInput = ~watchdogKickInput;
	endtask : kick
	// Reset request levels
	task automatic setReq(input logic fast, input logic lvl);
		if (fast)
			resetRequestFastN = lvl;
		else
			resetRequestSlowN = lvl;
	endtask : setReq
endmodule : raws_host

// File: bench/rtc_alarm_watchdog_supervisor_tb_top.sv
`timescale 1ns/1ps
module rtc_alarm_watchdog_supervisor_tb_top;
	logic       clock = 1'b0;
	logic       rstn = 1'b0;
	logic       secondsUpdate = 1'b0;
	logic       oscillatorStopBit = 1'b0;
	logic       batteryBackup = 1'b0;
	logic       powerFailTrip = 1'b0;
	logic       outputLevelBit = 1'b1;
	logic       batteryLow = 1'b0;
	logic [7:0] cv [5];
	logic [7:0] al [5] = '{8'h12, 8'h25, 8'h13, 8'h45, 8'h30};
	logic       regWrite, regRead, watchdogKickInput, resetRequestFastN, resetRequestSlowN;
	logic [7:0] regAddr, regWdata, regRdata, addrPointer;
	logic       sharedIrqOeN, resetOeN, squareWavePin, fixed32kClockPin;
	int         fails = 0;
	int         n_compared = 0;
	int         cycles = 0;
	// Short counts keep the recovery and filter waits inside the run budget
	raws_supervisor #(.REC_CYC(50), .STOP_CYC(40), .SLOW_CYC(20), .HALF_CYC(2)) dut (
		.clock, .rstn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .addrPointer,
		.secondsUpdate, .clockMonth(cv[0]), .clockDate(cv[1]), .clockHour(cv[2]),
		.clockMin(cv[3]), .clockSec(cv[4]), .oscillatorStopBit, .recoveryTimeSelect(1'b0),
		.outputLevelBit, .batteryLow, .batteryBackup, .powerFailTrip,
		.watchdogKickInput, .resetRequestFastN, .resetRequestSlowN, .sharedIrqOut(),
		.sharedIrqOeN, .resetOut(), .resetOeN, .squareWavePin, .fixed32kClockPin,
		.frequencyTestBit()
	);
	raws_host host (
		.clock, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .addrPointer,
		.watchdogKickInput, .resetRequestFastN, .resetRequestSlowN
	);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #2 clock = ~clock;
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic sec();
		@(negedge clock);
		secondsUpdate = 1'b1;
		@(negedge clock);
		secondsUpdate = 1'b0;
	endtask : sec
	// Bounded wait for an open-drain enable to reach a level
	task automatic waitLvl(input logic rst, input logic lvl, input int lim, output int n);
		n = 0;
		while ((rst ? resetOeN : sharedIrqOeN) !== lvl && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask : waitLvl
	// Toggles of a square-wave pin over w cycles
	task automatic cnt(input logic f32, input int w, output int t);
		logic p;
		logic q;
		t = 0;
		p = f32 ? fixed32kClockPin : squareWavePin;
		repeat (w)
		begin
			cyc(1);
			q = f32 ? fixed32kClockPin : squareWavePin;
			t += (q !== p);
			p = q;
		end
	endtask : cnt
	// Alarm bytes, 0A last so the pointer stays off flags; rpt[i] is repeat bit i
	task automatic setAl(input logic [5:1] rpt, input logic [7:0] ctl);
		host.wr(8'h0E, al[4] | {rpt[1], 7'h00});
		host.wr(8'h0D, al[3] | {rpt[2], 7'h00});
		host.wr(8'h0C, al[2] | {rpt[3], 7'h00});
		host.wr(8'h0B, al[1] | {rpt[4], rpt[5], 6'h00});
		host.wr(8'h0A, al[0] | ctl);
	endtask : setAl
	// One seconds update with fields in mask wrong; judge pin and flag
	task automatic fire(input logic [4:0] mask, input logic exp);
		logic [7:0] d;
		foreach (cv[i])
			cv[i] = mask[i] ? al[i] ^ 8'h02 : al[i];
		sec();
		cyc(3);
		chk({7'h00, sharedIrqOeN}, {7'h00, !exp});
		host.rd(8'h0F, d);
		chk(d, {1'b0, exp, 6'h00});
		chk({7'h00, sharedIrqOeN}, 8'h01);
	endtask : fire
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] d;
		int n;
		chk({7'h00, resetOeN}, 8'h00);
		waitLvl(1, 1, 200, n);
		chk({7'h00, n >= 44 && n <= 56}, 8'h01);
		host.wr(8'h0F, 8'hFF);
		foreach (al[i])
		begin
			host.rd(i == 0 ? 8'h09 : i == 1 ? 8'h0A : i == 2 ? 8'h0F : i == 3 ? 8'h13 : 8'h10, d);
			chk(d, 8'h00);
		end
		batteryLow = 1'b1;
		outputLevelBit = 1'b0;
		host.rd(8'h0F, d);
		chk(d, 8'h10);
		chk({7'h00, sharedIrqOeN}, 8'h00);
		batteryLow = 1'b0;
		outputLevelBit = 1'b1;
	endtask : t_reset
	task automatic t_modes();
		logic [5:1] rpt;
		logic [7:0] d;
		for (int k = 0; k <= 5; k++)
		begin
			for (int i = 1; i <= 5; i++)
				rpt[i] = (k < i);
			setAl(rpt, 8'h80);
			fire(5'h00, 1'b1);
			for (int f = 0; f < 5; f++)
				fire(5'h10 >> f, f >= k);
		end
		setAl(5'b01111, 8'h80);
		fire(5'h1F, 1'b1);
		setAl(5'b10101, 8'h80);
		fire(5'h1F, 1'b1);
		setAl(5'h00, 8'h80);
		host.wr(8'h0B, 8'h00);
		fire(5'h00, 1'b0);
		host.rd(8'h0F, d);
		chk(d, 8'h00);
	endtask : t_modes
	task automatic t_ptr();
		logic [7:0] d;
		setAl(5'h1F, 8'h80);
		host.wr(8'h0E, 8'h80 | al[4]); // Pointer now rests on flags
		sec();
		cyc(4);
		chk({7'h00, sharedIrqOeN}, 8'h01);
		host.rd(8'h0A, d);
		cyc(3);
		chk({7'h00, sharedIrqOeN}, 8'h00);
		host.rd(8'h0F, d);
		chk(d, 8'h40);
	endtask : t_ptr
	task automatic t_bak();
		logic [7:0] d;
		int t;
		setAl(5'h1F, 8'h80);
		batteryBackup = 1'b1;
		sec();
		cyc(3);
		chk({7'h00, sharedIrqOeN}, 8'h01);
		cnt(1, 64, t);
		chk(t[7:0], 8'h00);
		batteryBackup = 1'b0;
		host.rd(8'h0F, d);
		chk(d, 8'h40);
		host.wr(8'h0A, 8'hA0 | al[0]);
		batteryBackup = 1'b1;
		sec();
		cyc(3);
		chk({7'h00, sharedIrqOeN}, 8'h00);
		batteryBackup = 1'b0;
		host.rd(8'h0F, d);
	endtask : t_bak
	task automatic t_sqw();
		int t;
		int e;
		host.wr(8'h0A, 8'h40);
		for (int r = 1; r < 16; r++)
		begin
			host.wr(8'h13, {r[3:0], 4'h0});
			cyc(4);
			cnt(0, 512, t);
			e = 1024 / (r == 1 ? 4 : 4 << r);
			chk({7'h00, t >= e - 2 && t <= e + 2}, 8'h01);
		end
		host.wr(8'h13, 8'h00);
		cnt(0, 64, t);
		chk(t[7:0], 8'h00);
		host.wr(8'h13, 8'h10);
		host.wr(8'h0A, 8'h00);
		cnt(0, 64, t);
		chk(t[7:0], 8'h00);
		cnt(1, 512, t);
		chk({7'h00, t >= 254 && t <= 258}, 8'h01);
		oscillatorStopBit = 1'b1;
		cyc(4);
		cnt(1, 64, t);
		chk(t[7:0], 8'h00);
		oscillatorStopBit = 1'b0;
	endtask : t_sqw
	task automatic t_wd();
		logic [7:0] d;
		logic bad;
		int n;
		host.wr(8'h09, 8'h08); // Two sixteenths, interrupt steering
		waitLvl(0, 0, 30000, n);
		chk({7'h00, n >= 8000 && n <= 24600}, 8'h01);
		host.rd(8'h0F, d);
		chk(d, 8'h80);
		chk({7'h00, sharedIrqOeN}, 8'h00);
		host.wr(8'h09, 8'h00);
		cyc(2);
		chk({7'h00, sharedIrqOeN}, 8'h01);
		host.wr(8'h0A, 8'hE0);
		host.wr(8'h09, 8'h84); // One sixteenth, reset steering
		waitLvl(1, 0, 20000, n);
		chk({7'h00, n < 20000}, 8'h01);
		waitLvl(1, 1, 200, n);
		chk({7'h00, n >= 48 && n <= 54}, 8'h01);
		host.rd(8'h09, d);
		chk(d, 8'h00);
		host.rd(8'h0A, d);
		chk(d, 8'h00);
		host.rd(8'h0F, d);
		chk(d, 8'h80);
		bad = 1'b0;
		host.wr(8'h09, 8'h08);
		for (int i = 0; i < 8; i++)
		begin
			cyc(3500);
			host.kick();
			bad |= (sharedIrqOeN !== 1'b1);
		end
		chk({7'h00, bad}, 8'h00);
		host.wr(8'h09, 8'h00);
	endtask : t_wd
	// Source 0 is supply, 1 the fast request, 2 the slow one
	task automatic req(input int src, input int w, input logic exp);
		logic seen;
		int n;
		seen = 1'b0;
		if (src == 0)
			powerFailTrip = 1'b1;
		else
			host.setReq(src == 1, 1'b0);
		repeat (w)
		begin
			cyc(1);
			seen |= (resetOeN === 1'b0);
		end
		if (src == 0)
			powerFailTrip = 1'b0;
		else
			host.setReq(src == 1, 1'b1);
		waitLvl(1, 1, 300, n);
		chk({7'h00, seen}, {7'h00, exp});
		if (exp)
			chk({7'h00, n >= 48 && n <= 58}, 8'h01);
	endtask : req
	initial
	begin
		foreach (cv[i])
			cv[i] = 8'h00;
		cyc(8);
		rstn = 1'b1;
		t_reset();
		t_modes();
		t_ptr();
		t_bak();
		t_sqw();
		t_wd();
		req(0, 10, 1'b1);
		req(1, 60, 1'b1);
		req(1, 10, 1'b0);
		req(2, 30, 1'b1);
		req(2, 5, 1'b0);
		test_done();
	end
endmodule : rtc_alarm_watchdog_supervisor_tb_top
